// File: logic/mts_consts.svh
// Offsets, field positions, reset values and the two indexes for the test/strap registers
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH
`define MTS_EXT_PORT        16'h03CF
`define MTS_IDX_TEST_CTRL   8'h96
`define MTS_IDX_STRAP_RB    8'h97
`define MTS_BIT_LATCH_ID    0
`define MTS_BIT_DATA_TRI    2
`define MTS_BIT_ADDR_TRI    3
`define MTS_CTRL_WMASK      8'h0D
`define MTS_CTRL_RST        8'h00
`define MTS_STRAP_RST       8'h00
`define MTS_ID_RST          3'h0
`endif

// File: logic/mts_pkg.sv
// Types shared by the test/strap register block
package mts_pkg;
	typedef enum logic [1:0] {
		MTS_SNS_RESET = 2'b00,
		MTS_SNS_IDLE  = 2'b01,
		MTS_SNS_ARMED = 2'b10
	} mts_sense_e;
	typedef logic [7:0] mts_byte_t;
endpackage

// File: logic/mts_regs.sv
// Memory test control and strap readback extension registers
`timescale 1ns/1ps
`include "mts_consts.svh"
// Function
// - The test control register answers at port 3CF under index 96.
// - The strap readback register answers at port 3CF under index 97 and is read only.
// - Control bit 3 set floats both address buses and the memory strobes.
// - Control bit 3 clear drives address and strobes normally.
// - Control bit 2 set floats memory data buses zero and two, clear lets them run.
// - ID inputs are sampled while bit 0 is one and latched when it returns to zero.
// - Readback bits 7 to 4 show the four strap pull-ups, zero when absent.
// - Straps are sensed at reset and again whenever bit 0 returns from one to zero.
module mts_regs #(
	parameter int ID_W = 3
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic             clk_en,
	input  wire logic [15:0]      io_addr,
	input  wire logic             io_wr,
	input  wire logic             io_rd,
	input  wire logic [7:0]       index_val,
	input  wire logic [7:0]       io_wdata,
	output mts_pkg::mts_byte_t    io_rdata,
	output logic                  io_rvalid,
	input  wire logic [3:0]       strap_in,
	input  wire logic [ID_W-1:0]  mon_id_in,
	output logic                  mem_addr_ctl_oe,
	output logic                  mem_data_02_oe,
	output logic [ID_W-1:0]       monitor_identification
);
	import mts_pkg::*;
	initial begin
		if (ID_W < 1 || ID_W > 8) $error("ID_W out of range");
	end
	function automatic logic hit(input logic [15:0] a, input logic [7:0] i,
		input logic [7:0] want);
		hit = (a == `MTS_EXT_PORT) && (i == want);
	endfunction
	mts_byte_t       ctrl_reg, ctrl_next;
	mts_byte_t       rdata_reg, rdata_next;
	logic            rvalid_reg, rvalid_next;
	logic            aoe_reg, aoe_next;
	logic            doe_reg, doe_next;
	logic [ID_W-1:0] id_out_reg;
	logic [3:0]      strap_val;
	logic [ID_W-1:0] id_val;
	mts_sense #(.ID_W(ID_W)) u_sense (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.clk_en     (clk_en),
		.latch_bit  (ctrl_reg[`MTS_BIT_LATCH_ID]),
		.strap_in   (strap_in),
		.mon_id_in  (mon_id_in),
		.strap_val  (strap_val),
		.mon_id_val (id_val)
	);
	always_comb begin
		ctrl_next   = ctrl_reg;
		rdata_next  = 8'h00;
		rvalid_next = io_rd;
		// Reserved bits masked so they stay zero whatever software writes
		if (io_wr && hit(io_addr, index_val, `MTS_IDX_TEST_CTRL)) begin
			ctrl_next = io_wdata & `MTS_CTRL_WMASK;
		end
		// Writes to the readback index are dropped
		if (io_rd && hit(io_addr, index_val, `MTS_IDX_TEST_CTRL)) begin
			rdata_next = ctrl_reg;
		end else if (io_rd && hit(io_addr, index_val, `MTS_IDX_STRAP_RB)) begin
			rdata_next = {strap_val, 4'h0};
		end
		aoe_next = !ctrl_next[`MTS_BIT_ADDR_TRI];
		doe_next = !ctrl_next[`MTS_BIT_DATA_TRI];
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg   <= `MTS_CTRL_RST;
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
			aoe_reg    <= 1'b1;
			doe_reg    <= 1'b1;
			id_out_reg <= '0;
		end else if (clk_en) begin
			ctrl_reg   <= ctrl_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
			aoe_reg    <= aoe_next;
			doe_reg    <= doe_next;
			id_out_reg <= id_val;
		end
	end
	assign io_rdata               = rdata_reg;
	assign io_rvalid              = rvalid_reg;
	assign mem_addr_ctl_oe        = aoe_reg;
	assign mem_data_02_oe         = doe_reg;
	assign monitor_identification = id_out_reg;
endmodule // mts_regs

// File: logic/mts_sense.sv
// Strap and monitor ID sense sequencer
`timescale 1ns/1ps
`include "mts_consts.svh"
module mts_sense #(
	parameter int ID_W = 3
) (
	input  wire logic            core_clk,
	input  wire logic            nrst,
	input  wire logic            clk_en,
	input  wire logic            latch_bit,
	input  wire logic [3:0]      strap_in,
	input  wire logic [ID_W-1:0] mon_id_in,
	output logic      [3:0]      strap_val,
	output logic      [ID_W-1:0] mon_id_val
);
	import mts_pkg::*;
	initial begin
		if (ID_W < 1 || ID_W > 8) $error("ID_W out of range");
	end
	mts_sense_e            st_reg, st_next;
	logic [3:0]            strap_reg, strap_next;
	logic [ID_W-1:0]       samp_reg, samp_next;
	logic [ID_W-1:0]       id_reg, id_next;
	always_comb begin
		st_next    = st_reg;
		strap_next = strap_reg;
		samp_next  = samp_reg;
		id_next    = id_reg;
		case (st_reg)
			MTS_SNS_RESET: begin
				strap_next = strap_in;
				st_next    = MTS_SNS_IDLE;
			end
			MTS_SNS_IDLE: begin
				if (latch_bit) begin
					samp_next = mon_id_in;
					st_next   = MTS_SNS_ARMED;
				end
			end
			MTS_SNS_ARMED: begin
				if (latch_bit) begin
					samp_next = mon_id_in;
				end else begin
					id_next    = samp_reg;
					strap_next = strap_in;
					st_next    = MTS_SNS_IDLE;
				end
			end
			default: st_next = MTS_SNS_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg    <= MTS_SNS_RESET;
			strap_reg <= 4'h0;
			samp_reg  <= '0;
			id_reg    <= '0;
		end else if (clk_en) begin
			st_reg    <= st_next;
			strap_reg <= strap_next;
			samp_reg  <= samp_next;
			id_reg    <= id_next;
		end
	end
	assign strap_val  = strap_reg;
	assign mon_id_val = id_reg;
endmodule // mts_sense

// File: sim/memory_test_strap_readback_tb.sv
// Self-checking bench for the test/strap registers
`timescale 1ns/1ps
module memory_test_strap_readback_tb;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        io_wr, io_rd, io_rvalid, ao, do2;
	logic [15:0] io_addr;
	logic [7:0]  index_val, io_wdata, io_rdata, q, d;
	logic [3:0]  strap_in, sv;
	logic [2:0]  mon_id_in = 3'h0, id, idm = 3'h0;
	int          n_errors = 0, n_tests = 0, ctrl = 0, k;
	always #2.5 core_clk = ~core_clk;
	mts_regs u_dut (.core_clk, .nrst, .clk_en(1'b1), .io_addr, .io_wr, .io_rd, .index_val,
		.io_wdata, .io_rdata, .io_rvalid, .strap_in, .mon_id_in, .mem_addr_ctl_oe(ao),
		.mem_data_02_oe(do2), .monitor_identification(id));
	mts_host u_host (.core_clk, .io_addr, .io_wr, .io_rd, .index_val, .io_wdata, .io_rdata,
		.io_rvalid);
	task automatic cmp(input logic [7:0] g, e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		complete_run;
	end
	initial begin
		void'($urandom(18));
		strap_in = 4'($urandom);
		sv = strap_in;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		// Let the reset-time strap sense take sv before the straps move
		repeat (2) @(negedge core_clk);
		for (int n = 0; n < 24; n++) begin
			k = $urandom % 4;
			d = 8'($urandom);
			// Inputs move only while no capture is open
			if (ctrl[0] == 0) begin
				strap_in = 4'($urandom);
				mon_id_in = 3'($urandom);
			end
			// Only k of 0 reaches the control register; the rest must be ignored
			u_host.acc(1'b1, k == 2 ? 16'h03CE : 16'h03CF,
				k == 1 ? 8'h97 : (k == 3 ? 8'h98 : 8'h96), d, q);
			if (k == 0 && ctrl[0] && !d[0]) begin
				sv = strap_in;
				idm = mon_id_in;
			end
			if (k == 0) ctrl = d & 8'h0D;
			// No display here, so blanking and the frame wait shrink to 3 cycles
			repeat (3) @(negedge core_clk);
			u_host.acc(1'b0, 16'h03CF, 8'h96, 8'h0, q);
			cmp(q, 8'(ctrl));
			u_host.acc(1'b0, 16'h03CF, 8'h97, 8'h0, q);
			cmp(q, {sv, 4'h0});
			u_host.acc(1'b0, 16'h03CF, 8'h98, 8'h0, q);
			cmp(q, 8'h00);
			cmp({ao, do2, id}, {!ctrl[3], !ctrl[2], idm});
		end
		complete_run;
	end
endmodule // memory_test_strap_readback_tb

// File: sim/mts_host.sv
// Host processor model on the indexed I/O port
`timescale 1ns/1ps
module mts_host (
	input  wire logic               core_clk,
	output logic [15:0]             io_addr = 16'h0,
	output logic                    io_wr = 1'b0,
	output logic                    io_rd = 1'b0,
	output logic [7:0]              index_val = 8'h0,
	output logic [7:0]              io_wdata = 8'h0,
	input  wire mts_pkg::mts_byte_t io_rdata,
	input  wire logic               io_rvalid
);
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] i, d,
		output logic [7:0] q);
		@(negedge core_clk);
		io_addr = a;
		index_val = i;
		io_wdata = d & 8'h1F;
		io_wr = w;
		io_rd = !w;
		@(negedge core_clk);
		io_wr = 1'b0;
		io_rd = 1'b0;
		// Released data flips so a stale byte never looks valid
		io_wdata = ~io_wdata;
		q = io_rvalid === 1'b1 ? io_rdata : 8'hXX;
	endtask
endmodule // mts_host

// File: sim/mts_regs_chk.sv
// Port assertions for the test/strap registers
`timescale 1ns/1ps
module mts_regs_chk (
	input wire logic               core_clk,
	input wire logic               nrst,
	input wire logic               clk_en,
	input wire logic [15:0]        io_addr,
	input wire logic               io_wr,
	input wire logic               io_rd,
	input wire logic [7:0]         index_val,
	input wire logic [7:0]         io_wdata,
	input wire mts_pkg::mts_byte_t io_rdata,
	input wire logic               io_rvalid,
	input wire logic               mem_addr_ctl_oe,
	input wire logic               mem_data_02_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire hit = clk_en && io_addr == 16'h03CF;
	wire w96 = hit && io_wr && index_val == 8'h96;
	wire r96 = hit && io_rd && index_val == 8'h96;
	wire r97 = hit && io_rd && index_val == 8'h97;
	chk_rd_answer: assert property (io_rd && clk_en |=> io_rvalid)
		else $error("read not answered");
	chk_addr_float: assert property (w96 |=> mem_addr_ctl_oe != $past(io_wdata[3]))
		else $error("address float wrong");
	chk_data_float: assert property (w96 |=> mem_data_02_oe != $past(io_wdata[2]))
		else $error("data float wrong");
	chk_oe_hold: assert property (!w96 |=> $stable({mem_addr_ctl_oe, mem_data_02_oe}))
		else $error("enables moved");
	chk_strap_low: assert property (r97 |=> io_rdata[3:0] == 4'h0)
		else $error("readback low bits set");
	chk_ctrl_resv: assert property (r96 |=> (io_rdata & 8'hF2) == 8'h00)
		else $error("control reserved set");
	chk_ctrl_echo: assert property (r96 && !io_wr |=> io_rdata[3:2] == ~{mem_addr_ctl_oe,
		mem_data_02_oe}) else $error("control echo wrong");
	chk_miss_zero: assert property (io_rd && clk_en && !r96 && !r97 |=> io_rdata == 8'h00)
		else $error("miss read not zero");
endmodule // mts_regs_chk
bind mts_regs mts_regs_chk u_chk (.core_clk, .nrst, .clk_en, .io_addr, .io_wr, .io_rd,
	.index_val, .io_wdata, .io_rdata, .io_rvalid, .mem_addr_ctl_oe, .mem_data_02_oe);
